// ### verilog/tape_exec_consts.svh
// constants and behaviour notes for the tape command executor
// Notes on behaviour
// [R1] write modifier 001 means write then verify
// [R2] verify rereads every written block afterwards
// [R3] verify ok: code 000 first try, 001 retries
// [R4] unrecoverable verify readback ends with code 372
// [R5] buffer holds at most 128 bytes per packet
// [R6] host waits for continue before next packet
// [R7] continue is single byte octal 020
// [R8] op 5 positions unit to block, end packet
// [R9] op codes 4, 6, 10, 11 are reserved
// [R10] op 7 runs diagnostic, code reports outcome
// [R11] op 8 returns present status, else nop
// [R12] op 9 only returns end packet
// [R13] long transfers continue through consecutive blocks
// [R14] crossing 127/128, 255/256, 383/384 forces rewind
// [R15] soft errors reported in end byte 3
// [R16] reserved op answered with bad instruction code
// [R17] end flag 002, data flag 001
// [R18] transmit-off stops sending until continue arrives
// [R19] partial block padded with zero bytes
// [R20] no new instruction until end packet sent
`ifndef TAPE_EXEC_CONSTS_SVH
`define TAPE_EXEC_CONSTS_SVH
`define OP_NOP        4'h0
`define OP_INIT       4'h1
`define OP_READ       4'h2
`define OP_WRITE      4'h3
`define OP_POSITION   4'h5
`define OP_DIAGNOSE   4'h7
`define OP_GET_STATUS 4'h8
`define OP_SET_STATUS 4'h9
`define MOD_VERIFY    8'h01
`define FLAG_DATA     8'h01
`define FLAG_END      8'h02
`define OP_END        8'h40
`define CHAR_CONTINUE 8'h10
`define CHAR_XOFF     8'h13
`define SC_OK         8'h00
`define SC_RETRY      8'h01
`define SC_BAD_OP     8'hD0
`define SC_HARD_READ  8'hFA
`define SC_DIAG_FAIL  8'hF7
`define END_LEN       8'h0A
`define BUF_BYTES     128
`define BUF_AW        7
`define BLOCK_BYTES   16'd512
`define RW_BOUND_A    16'd128
`define RW_BOUND_B    16'd256
`define RW_BOUND_C    16'd384
`endif

// ### verilog/tape_exec_pkg.sv
// types shared by the tape command executor
package tape_exec_pkg;
  typedef struct packed {
    logic [3:0]  opcode;
    logic [7:0]  modifier;
    logic [7:0]  unit;
    logic [15:0] byte_count;
    logic [15:0] block;
  } cmd_t;
  typedef struct packed {
    logic        req;
    logic        write;
    logic [7:0]  unit;
    logic [15:0] block;
    logic        rewind;
  } tape_req_t;
  typedef struct packed {
    logic       done;
    logic       ok;
    logic       retried;
  } tape_rsp_t;
endpackage

// ### verilog/tape_exec_buf.sv
// 128-byte write data buffer with registered read data
module tape_exec_buf
(
  input  wire logic       clk_sys,
  input  wire logic       we,
  input  wire logic [6:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [6:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:127];

  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### verilog/tape_command_executor.sv
// command execution engine: write, verify, position, diagnose, status, end packets
`include "tape_exec_consts.svh"
module tape_command_executor
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     cmd_valid,
  input  wire tape_exec_pkg::cmd_t      cmd,
  input  wire logic                     wr_valid,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     wr_last,
  input  wire logic                     rx_valid,
  input  wire logic [7:0]               rx_char,
  input  wire logic                     tx_ready,
  input  wire tape_exec_pkg::tape_rsp_t tape_rsp,
  input  wire logic                     diag_done,
  input  wire logic                     diag_pass,
  output logic                          busy,
  output logic                          tx_valid,
  output logic [7:0]                    tx_byte,
  output tape_exec_pkg::tape_req_t      tape_req,
  output logic [7:0]                    tape_wbyte,
  output logic                          tape_wstrobe,
  output logic                          diag_start
);
  import tape_exec_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_FILL, S_SEEK, S_WBLK, S_PAD, S_CONT, S_VSEEK, S_DIAG, S_END
  } state_t;

  state_t      state_q;
  cmd_t        cmd_q;
  logic [7:0]  code_q;
  logic [7:0]  status_q;
  logic [15:0] remain_q;
  logic [15:0] blk_q;
  logic [15:0] vblk_q;
  logic [15:0] wblks_q;
  logic [9:0]  bpos_q;
  logic [7:0]  fill_q;
  logic [7:0]  rd_q;
  logic        retry_q;
  logic        hold_q;
  logic        pend_q;
  logic [3:0]  eidx_q;
  logic        tape_wait_q;

  wire op_reserved = (cmd.opcode == 4'h4) || (cmd.opcode == 4'h6)
                   || (cmd.opcode == 4'hA) || (cmd.opcode == 4'hB)
                   || (cmd.opcode > 4'hB);
  wire verify_on   = (cmd_q.opcode == `OP_WRITE) && (cmd_q.modifier == `MOD_VERIFY);
  wire fill_full   = (fill_q == 8'(`BUF_BYTES));
  wire fill_take   = (state_q == S_FILL) && wr_valid && !fill_full;
  wire data_left   = (rd_q != fill_q);
  wire blk_end     = (bpos_q == 10'(`BLOCK_BYTES - 16'd1));
  wire tx_go       = tx_valid && tx_ready;
  wire [7:0] buf_rd;
  wire [15:0] seek_blk = (state_q == S_VSEEK) ? vblk_q : cmd_q.block;
  // a boundary crossing is any move between different 128-block groups of the tape
  wire cross_rw    = (blk_q[8:7] != seek_blk[8:7]) || (blk_q[15:9] != seek_blk[15:9]);

  // [R5] 128 byte buffer
  tape_exec_buf u_buf
  (
    .clk_sys (clk_sys),
    .we      (fill_take),
    .waddr   (fill_q[6:0]),
    .wdata   (wr_data),
    .raddr   (rd_q[6:0]),
    .rdata   (buf_rd)
  );

  // end packet byte selection
  logic [7:0] end_byte;
  always_comb
  begin
    end_byte = 8'h00;
    unique case (eidx_q)
      // [R17] end flag value
      4'd0: end_byte = `FLAG_END;
      4'd1: end_byte = `END_LEN;
      4'd2: end_byte = `OP_END;
      // [R15] success code byte
      4'd3: end_byte = code_q;
      4'd4: end_byte = cmd_q.unit;
      // [R11] present status carried
      4'd11: end_byte = (cmd_q.opcode == `OP_GET_STATUS) ? status_q : 8'h00;
      default: end_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      cmd_q <= '0;
      code_q <= 8'h00;
      status_q <= 8'h00;
      remain_q <= 16'h0000;
      blk_q <= 16'h0000;
      vblk_q <= 16'h0000;
      wblks_q <= 16'h0000;
      bpos_q <= 10'h000;
      fill_q <= 8'h00;
      rd_q <= 8'h00;
      retry_q <= 1'b0;
      hold_q <= 1'b0;
      pend_q <= 1'b0;
      eidx_q <= 4'h0;
      tape_wait_q <= 1'b0;
      busy <= 1'b0;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      tape_req <= '0;
      tape_wbyte <= 8'h00;
      tape_wstrobe <= 1'b0;
      diag_start <= 1'b0;
    end
    else
    begin
      tape_req.req <= 1'b0;
      tape_wstrobe <= 1'b0;
      diag_start <= 1'b0;
      // [R18] transmit-off holds output
      if (rx_valid && rx_char == `CHAR_XOFF)
      begin
        hold_q <= 1'b1;
      end
      else if (rx_valid && rx_char == `CHAR_CONTINUE)
      begin
        hold_q <= 1'b0;
      end
      if (tx_go)
      begin
        tx_valid <= 1'b0;
      end
      unique case (state_q)
        S_IDLE:
        begin
          busy <= 1'b0;
          // [R20] start after end sent
          if (cmd_valid && !tx_valid)
          begin
            cmd_q <= cmd;
            busy <= 1'b1;
            retry_q <= 1'b0;
            code_q <= `SC_OK;
            remain_q <= cmd.byte_count;
            bpos_q <= 10'h000;
            fill_q <= 8'h00;
            rd_q <= 8'h00;
            wblks_q <= 16'h0000;
            // [R9] reserved codes rejected
            if (op_reserved)
            begin
              // [R16] bad instruction code
              code_q <= `SC_BAD_OP;
              state_q <= S_END;
            end
            // [R8] position to block
            else if (cmd.opcode == `OP_POSITION || cmd.opcode == `OP_WRITE)
            begin
              state_q <= S_SEEK;
            end
            // [R10] run diagnostic
            else if (cmd.opcode == `OP_DIAGNOSE)
            begin
              diag_start <= 1'b1;
              state_q <= S_DIAG;
            end
            // [R12] no tape action
            else
            begin
              state_q <= S_END;
            end
          end
        end
        S_SEEK, S_VSEEK:
        begin
          if (!tape_wait_q)
          begin
            tape_req.req <= 1'b1;
            tape_req.write <= 1'b0;
            tape_req.unit <= cmd_q.unit;
            tape_req.block <= seek_blk;
            // [R14] rewind on boundary
            tape_req.rewind <= cross_rw;
            tape_wait_q <= 1'b1;
          end
          else if (tape_rsp.done)
          begin
            tape_wait_q <= 1'b0;
            blk_q <= tape_req.block;
            if (tape_rsp.retried)
            begin
              retry_q <= 1'b1;
            end
            if (state_q == S_VSEEK)
            begin
              // [R4] hard read error
              if (!tape_rsp.ok)
              begin
                code_q <= `SC_HARD_READ;
                state_q <= S_END;
              end
              // [R2] reread each block
              else if (vblk_q + 16'd1 == cmd_q.block + wblks_q)
              begin
                // [R3] first try or retries
                code_q <= (retry_q || tape_rsp.retried) ? `SC_RETRY : `SC_OK;
                state_q <= S_END;
              end
              else
              begin
                vblk_q <= vblk_q + 16'd1;
                tape_wait_q <= 1'b0;
              end
            end
            else if (cmd_q.opcode == `OP_WRITE && remain_q != 16'h0000)
            begin
              state_q <= S_CONT;
            end
            else
            begin
              state_q <= S_END;
            end
          end
        end
        S_CONT:
        begin
          // [R7] continue byte
          if (!tx_valid && !hold_q)
          begin
            tx_valid <= 1'b1;
            tx_byte <= `CHAR_CONTINUE;
            fill_q <= 8'h00;
            rd_q <= 8'h00;
            state_q <= S_FILL;
          end
        end
        S_FILL:
        begin
          // [R6] host sends one packet
          if (fill_take)
          begin
            fill_q <= fill_q + 8'h01;
          end
          if (wr_valid && (wr_last || fill_full))
          begin
            pend_q <= 1'b1;
            state_q <= S_WBLK;
          end
        end
        S_WBLK:
        begin
          pend_q <= 1'b0;
          if (!pend_q)
          begin
            if (data_left && remain_q != 16'h0000)
            begin
              tape_wstrobe <= 1'b1;
              tape_wbyte <= buf_rd;
              rd_q <= rd_q + 8'h01;
              remain_q <= remain_q - 16'h0001;
              // wrap at the block end so every block boundary is seen once
              bpos_q <= blk_end ? 10'h000 : bpos_q + 10'h001;
              pend_q <= 1'b1;
              // [R13] next consecutive block
              if (blk_end)
              begin
                wblks_q <= wblks_q + 16'h0001;
              end
            end
            else if (remain_q != 16'h0000)
            begin
              state_q <= S_CONT;
            end
            else
            begin
              state_q <= S_PAD;
            end
          end
        end
        S_PAD:
        begin
          // [R19] zero fill block
          if (bpos_q != 10'h000)
          begin
            tape_wstrobe <= 1'b1;
            tape_wbyte <= 8'h00;
            bpos_q <= blk_end ? 10'h000 : bpos_q + 10'h001;
            if (blk_end)
            begin
              wblks_q <= wblks_q + 16'h0001;
            end
          end
          // [R1] verify after write
          else if (verify_on && wblks_q != 16'h0000)
          begin
            vblk_q <= cmd_q.block;
            state_q <= S_VSEEK;
          end
          else
          begin
            state_q <= S_END;
          end
        end
        S_DIAG:
        begin
          if (diag_done)
          begin
            code_q <= diag_pass ? `SC_OK : `SC_DIAG_FAIL;
            status_q <= diag_pass ? 8'h00 : `SC_DIAG_FAIL;
            state_q <= S_END;
          end
        end
        S_END:
        begin
          if ((!tx_valid || tx_go) && !hold_q)
          begin
            tx_valid <= 1'b1;
            tx_byte <= end_byte;
            if (eidx_q == 4'd13)
            begin
              eidx_q <= 4'h0;
              state_q <= S_IDLE;
            end
            else
            begin
              eidx_q <= eidx_q + 4'h1;
            end
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ### bench/tape_exec_sva.sv
// port assertions for the tape command executor
`include "tape_exec_consts.svh"
module tape_exec_sva
(
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire logic                     cmd_valid,
  input wire tape_exec_pkg::cmd_t      cmd,
  input wire logic                     tx_ready,
  input wire logic                     busy,
  input wire logic                     tx_valid,
  input wire logic [7:0]               tx_byte,
  input wire tape_exec_pkg::tape_req_t tape_req,
  input wire logic                     tape_wstrobe,
  input wire logic                     diag_start
);
  import tape_exec_pkg::*;
  logic       take;
  logic       tx_go;
  logic [3:0] end_cnt_q;
  assign take  = cmd_valid && !busy && !tx_valid;
  assign tx_go = tx_valid && tx_ready;
  // position inside an end packet, so a byte resumed after transmit-off is no start
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      end_cnt_q <= 4'h0;
    end
    else if (tx_go && end_cnt_q != 4'h0)
    begin
      end_cnt_q <= (end_cnt_q == 4'd13) ? 4'h0 : end_cnt_q + 4'h1;
    end
    else if (tx_go && tx_byte == `FLAG_END)
    begin
      end_cnt_q <= 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_TAKE_BUSY: assert property (take |=> busy)
    else $error("command taken but executor idle");
  AST_TX_STANDS: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("outgoing byte dropped or changed");
  AST_FIRST_BYTE: assert property (tx_valid && end_cnt_q == 4'h0
    |-> tx_byte == `FLAG_END || tx_byte == `CHAR_CONTINUE)
    else $error("transmission starts with wrong byte");
  AST_REQ_PULSE: assert property (tape_req.req |=> !tape_req.req)
    else $error("tape request longer than one cycle");
  AST_DIAG_PULSE: assert property (diag_start |=> !diag_start)
    else $error("diagnostic start longer than one cycle");
  AST_DIAG_GO: assert property (take && cmd.opcode == 4'h7 |-> ##[1:16] diag_start)
    else $error("diagnose did not start diagnostic");
  AST_POS_GO: assert property (take && cmd.opcode == 4'h5
    |-> ##[1:16] tape_req.req && !tape_req.write)
    else $error("position issued no seek");
  AST_QUIET_OPS: assert property (take && cmd.opcode inside {4'h4, 4'h6, 4'h9, 4'hA, 4'hB}
    |=> (!tape_req.req && !tape_wstrobe && !diag_start) [*8])
    else $error("tape activity on reserved or set status");
  AST_STROBE_BUSY: assert property (tape_wstrobe |-> busy)
    else $error("tape write outside instruction");
endmodule
bind tape_command_executor tape_exec_sva u_tape_exec_sva
(
  .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .tx_ready(tx_ready),
  .busy(busy), .tx_valid(tx_valid), .tx_byte(tx_byte), .tape_req(tape_req),
  .tape_wstrobe(tape_wstrobe), .diag_start(diag_start)
);

// ### bench/tape_mech_model.sv
// behavioural tape mechanics and diagnostic responder
module tape_mech_model
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire tape_exec_pkg::tape_req_t tape_req,
  input  wire logic [7:0]               tape_wbyte,
  input  wire logic                     tape_wstrobe,
  input  wire logic                     diag_start,
  input  wire logic                     fail_rd,
  input  wire logic                     retry_rd,
  input  wire logic                     diag_ok,
  input  wire logic [7:0]               lat,
  output tape_exec_pkg::tape_rsp_t      tape_rsp,
  output logic                          diag_done,
  output logic                          diag_pass
);
  import tape_exec_pkg::*;
  logic [7:0]  mem[4096];
  int          nwr, nreq, t_q, d_q;
  logic        rd_q, last_rewind;
  logic [7:0]  last_unit;
  logic [15:0] last_block;
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      nwr <= 0;
      nreq <= 0;
      t_q <= 0;
      d_q <= 0;
      rd_q <= 1'b0;
      tape_rsp <= '0;
      diag_done <= 1'b0;
      diag_pass <= 1'b0;
    end
    else
    begin
      // idle fields show the opposite answer so nothing passes by luck
      tape_rsp <= '{1'b0, rd_q && fail_rd, !(rd_q && retry_rd)};
      diag_done <= 1'b0;
      diag_pass <= !diag_ok;
      if (tape_wstrobe)
        mem[nwr] <= tape_wbyte;
      if (tape_wstrobe)
        nwr <= nwr + 1;
      if (tape_req.req)
      begin
        t_q <= tape_req.rewind ? 4 * lat + 1 : lat + 1;
        rd_q <= !tape_req.write;
        nreq <= nreq + 1;
        last_block <= tape_req.block;
        last_unit <= tape_req.unit;
        last_rewind <= tape_req.rewind;
      end
      else if (t_q != 0)
        t_q <= t_q - 1;
      if (!tape_req.req && t_q == 1)
        tape_rsp <= '{1'b1, !(rd_q && fail_rd), rd_q && retry_rd};
      if (diag_start)
        d_q <= lat + 1;
      else if (d_q != 0)
        d_q <= d_q - 1;
      if (!diag_start && d_q == 1)
        diag_done <= 1'b1;
      if (!diag_start && d_q == 1)
        diag_pass <= diag_ok;
    end
  end
endmodule

// ### bench/test_tape_command_executor.sv
// self-checking bench for the tape command executor
`include "tape_exec_consts.svh"
module test_tape_command_executor;
  timeunit 1ns;
  timeprecision 1ns;
  import tape_exec_pkg::*;
  logic       clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0;
  logic       wr_last = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0, fail_rd = 1'b0;
  logic       retry_rd = 1'b0, diag_ok = 1'b1;
  logic [7:0] wr_data = 8'h00, rx_char = 8'h00, lat = 8'h03, tx_byte, tape_wbyte;
  cmd_t       cmd = '0;
  tape_rsp_t  tape_rsp;
  tape_req_t  tape_req;
  logic       diag_done, diag_pass, busy, tx_valid, tape_wstrobe, diag_start;
  logic [7:0] rxq[$];
  int         fails = 0;
  int         samples_checked = 0;
  logic [7:0] wmod = `MOD_VERIFY;
  logic [7:0] exp_st = 8'h00;
  tape_command_executor u_tape_command_executor
  (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_last(wr_last), .rx_valid(rx_valid), .rx_char(rx_char),
    .tx_ready(tx_ready), .tape_rsp(tape_rsp), .diag_done(diag_done), .diag_pass(diag_pass),
    .busy(busy), .tx_valid(tx_valid), .tx_byte(tx_byte), .tape_req(tape_req),
    .tape_wbyte(tape_wbyte), .tape_wstrobe(tape_wstrobe), .diag_start(diag_start)
  );
  tape_mech_model u_tape_mech_model
  (
    .clk_sys(clk_sys), .rst(rst), .tape_req(tape_req), .tape_wbyte(tape_wbyte),
    .tape_wstrobe(tape_wstrobe), .diag_start(diag_start), .fail_rd(fail_rd),
    .retry_rd(retry_rd), .diag_ok(diag_ok), .lat(lat), .tape_rsp(tape_rsp),
    .diag_done(diag_done), .diag_pass(diag_pass)
  );
  always #25 clk_sys = ~clk_sys;
  // stalling every other cycle makes each outgoing byte wait on tx_ready
  always @(posedge clk_sys)
  begin
    tx_ready <= ~tx_ready;
    if (tx_valid && tx_ready)
      rxq.push_back(tx_byte);
  end
  task give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task pop(output logic [7:0] b);
    int n;
    n = 0;
    while (rxq.size() == 0 && n < 4000)
    begin
      @(posedge clk_sys);
      n++;
    end
    b = (rxq.size() == 0) ? 8'hXX : rxq.pop_front();
  endtask
  task issue(input logic [3:0] op, input logic [7:0] un, input logic [15:0] cnt, blk);
    repeat (3) @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{op, (op == `OP_WRITE) ? wmod : 8'h00, un, cnt, blk};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask
  task send_ch(input logic [7:0] c);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
  endtask
  task endpkt(input logic [7:0] code, un, input int from);
    logic [7:0] b;
    for (int i = from; i < 14; i++)
    begin
      pop(b);
      if (i == 0) chk(b, `FLAG_END);
      if (i == 1) chk(b, `END_LEN);
      if (i == 2) chk(b, `OP_END);
      if (i == 3) chk(b, code);
      if (i == 4) chk(b, un);
      if (i == 11) chk(b, exp_st);
    end
  endtask
  task automatic t_nops();
    logic [3:0] ops[3] = '{`OP_NOP, `OP_GET_STATUS, `OP_SET_STATUS};
    int r;
    r = u_tape_mech_model.nreq;
    foreach (ops[i])
    begin
      issue(ops[i], 8'h02, 16'd0, 16'd0);
      endpkt(`SC_OK, 8'h02, 0);
    end
    chk(16'(u_tape_mech_model.nreq - r), 16'h0000);
  endtask
  task automatic t_reserved();
    logic [3:0] ops[4] = '{4'h4, 4'h6, 4'hA, 4'hB};
    foreach (ops[i])
    begin
      issue(ops[i], 8'h01, 16'd0, 16'd0);
      endpkt(`SC_BAD_OP, 8'h01, 0);
    end
  endtask
  task t_diag();
    diag_ok <= 1'b1;
    issue(`OP_DIAGNOSE, 8'h00, 16'd0, 16'd0);
    endpkt(`SC_OK, 8'h00, 0);
    diag_ok <= 1'b0;
    issue(`OP_DIAGNOSE, 8'h00, 16'd0, 16'd0);
    endpkt(`SC_DIAG_FAIL, 8'h00, 0);
    // a failed diagnostic leaves a status that get-status must carry
    exp_st = `SC_DIAG_FAIL;
    issue(`OP_GET_STATUS, 8'h00, 16'd0, 16'd0);
    endpkt(`SC_OK, 8'h00, 0);
    exp_st = 8'h00;
  endtask
  task t_position();
    issue(`OP_POSITION, 8'h03, 16'd0, 16'd200);
    endpkt(`SC_OK, 8'h03, 0);
    chk(u_tape_mech_model.last_block, 16'd200);
    chk({8'h00, u_tape_mech_model.last_unit}, 16'h0003);
    chk({15'h0, u_tape_mech_model.last_rewind}, 16'h0001);
    issue(`OP_POSITION, 8'h03, 16'd0, 16'd201);
    endpkt(`SC_OK, 8'h03, 0);
    chk({15'h0, u_tape_mech_model.last_rewind}, 16'h0000);
  endtask
  task t_xoff();
    logic [7:0] b;
    int n;
    issue(`OP_SET_STATUS, 8'h00, 16'd0, 16'd0);
    pop(b);
    chk(b, `FLAG_END);
    send_ch(`CHAR_XOFF);
    repeat (4) @(posedge clk_sys);
    n = rxq.size();
    repeat (30) @(posedge clk_sys);
    chk(16'(rxq.size()), 16'(n));
    send_ch(`CHAR_CONTINUE);
    // bytes caught before the stop are still queued, so the walk resumes at byte 1
    endpkt(`SC_OK, 8'h00, 1);
  endtask
  task t_write(input logic [15:0] cnt, input logic fl, rt, input logic [7:0] code);
    logic [7:0] b;
    int base, k, n, blk;
    fail_rd <= fl;
    retry_rd <= rt;
    base = u_tape_mech_model.nwr;
    issue(`OP_WRITE, 8'h00, cnt, 16'd10);
    k = 0;
    while (k < cnt)
    begin
      pop(b);
      chk(b, `CHAR_CONTINUE);
      n = (cnt - k > `BUF_BYTES) ? `BUF_BYTES : cnt - k;
      for (int i = 0; i < n; i++)
      begin
        @(posedge clk_sys);
        wr_valid <= 1'b1;
        wr_data <= 8'(k + i);
        wr_last <= (i == n - 1);
      end
      @(posedge clk_sys);
      wr_valid <= 1'b0;
      wr_last <= 1'b0;
      k += n;
    end
    endpkt(code, 8'h00, 0);
    blk = (cnt + 511) / 512 * 512;
    chk(16'(u_tape_mech_model.nwr - base), 16'(blk));
    for (int i = 0; i < blk; i++)
      chk({8'h00, u_tape_mech_model.mem[base + i]}, (i < cnt) ? 16'(i % 256) : 16'h0000);
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_nops();
    t_reserved();
    t_diag();
    t_position();
    t_xoff();
    t_write(16'd130, 1'b0, 1'b1, `SC_RETRY);
    lat <= 8'd40;
    t_write(16'd600, 1'b0, 1'b0, `SC_OK);
    t_write(16'd20, 1'b1, 1'b0, `SC_HARD_READ);
    // plain write: no readback, so a bad tape goes unseen
    wmod <= 8'h00;
    t_write(16'd20, 1'b1, 1'b0, `SC_OK);
    give_verdict();
  end
endmodule
